//--- design/nstpb_pkg.sv
// Constants for the navigation status, time and deviation packet builder.
// Assumes a single 20 MHz system clock shared by all users of the package.
package nstpb_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 50;
  localparam int USEC_NS = 1000;
  localparam int TICKS_PER_USEC = USEC_NS / CLK_PERIOD_NS;
  localparam logic [4:0] TICK_LAST = 5'(TICKS_PER_USEC - 1);
  localparam logic [19:0] USEC_MAX = 20'hF423F;
  localparam logic [31:0] SEC_RST = 32'h0000_0000;
  localparam logic [19:0] USEC_RST = 20'h0_0000;

  // Packet identifiers
  localparam logic [7:0] ID_STATE = 8'h14;
  localparam logic [7:0] ID_UNIX = 8'h15;
  localparam logic [7:0] ID_FMT = 8'h16;
  localparam logic [7:0] ID_STATUS = 8'h17;
  localparam logic [7:0] ID_POS_SD = 8'h18;
  localparam logic [7:0] ID_VEL_SD = 8'h19;
  localparam logic [7:0] ID_ORI_SD = 8'h1A;

  // Payload lengths in bytes
  localparam logic [6:0] LEN_STATE = 7'h64;
  localparam logic [6:0] LEN_UNIX = 7'h08;
  localparam logic [6:0] LEN_FMT = 7'h0E;
  localparam logic [6:0] LEN_STATUS = 7'h04;
  localparam logic [6:0] LEN_SD = 7'h0C;
  localparam logic [6:0] LEN_NONE = 7'h00;

  // Payload byte offsets
  localparam int OFS_SYS = 0;
  localparam int OFS_FILT = 2;
  localparam int OFS_SEC = 4;
  localparam int OFS_USEC = 8;
  localparam int OFS_STATE_SD = 88;
  localparam int OFS_FMT_YEAR = 4;
  localparam int OFS_FMT_YDAY = 6;
  localparam int OFS_FMT_MON = 8;
  localparam int OFS_FMT_MDAY = 9;
  localparam int OFS_FMT_WDAY = 10;
  localparam int OFS_FMT_HOUR = 11;
  localparam int OFS_FMT_MIN = 12;
  localparam int OFS_FMT_SEC = 13;

  // System status word: bits 0..14 come from the flag inputs
  localparam int SYS_OVF_BIT = 15;
  localparam int PAYLOAD_MAX = 100;

  typedef enum logic {NSTPB_IDLE, NSTPB_SEND} nstpb_st_t;

  function automatic logic [6:0] nstpb_len(input logic [7:0] id);
    case (id)
      ID_STATE: nstpb_len = LEN_STATE;
      ID_UNIX: nstpb_len = LEN_UNIX;
      ID_FMT: nstpb_len = LEN_FMT;
      ID_STATUS: nstpb_len = LEN_STATUS;
      ID_POS_SD, ID_VEL_SD, ID_ORI_SD: nstpb_len = LEN_SD;
      default: nstpb_len = LEN_NONE;
    endcase
  endfunction

endpackage

//--- design/nstpb_builder.sv
// Packet builder: status words, running Unix time and deviation payloads.
// Assumes flag and value inputs come from logic on CLK_SYS; the byte
// stream is drained by a serial framer through OUT_VALID / OUT_READY.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: The system status word is 16 bits; bits 0-5 flag system, accel, gyro, magnetometer, pressure and GNSS failure.
// R2: Every status flag bit is one for true and zero for false.
// R3: Bits 6-9 are over-range flags, 10-13 temperature and voltage alarms, 14 antenna disconnected.
// R4: Bit 15 of the system status word is set when the output path overflows.
// R5: The filter status word is 16 bits; bits 0-3 flag orientation, navigation, heading and UTC initialised.
// R6: Filter bits 4-8 are fix types, 9-12 enables, 13-15 external aids active.
// R7: The seconds field counts UTC seconds since 1970 without leap seconds.
// R8: The microseconds field counts since the last second and stays within 0 to 999999.
// R9: Packet 21 carries 8 bytes: seconds at offset 0, microseconds at offset 4.
// R10: Packet 22 carries 14 bytes: microseconds, year, year day, then month, day, week day, hour, minute, second bytes.
// R11: Packet 23 carries 4 bytes: system status at 0, filter status at 2.
// R12: Packet 24 carries 12 bytes: latitude, longitude, height deviation floats.
// R13: Packet 25 carries 12 bytes: north, east, down velocity deviation floats.
// R14: Packet 26 carries 12 bytes: roll, pitch, heading deviation floats.
// R15: Packet 20 is 100 bytes and opens with system status, filter status, seconds, microseconds at 0, 2, 4, 8.
// R16: Multi-byte fields go out least significant byte first, floats as IEEE-754 single.
module nstpb_builder (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [14:0] SYS_FLAGS,
  input wire logic [15:0] FILT_FLAGS,
  input wire logic OVF_CLR,
  input wire logic TIME_SET,
  input wire logic [31:0] TIME_SEC_SET,
  input wire logic [19:0] TIME_USEC_SET,
  input wire logic [15:0] FMT_YEAR,
  input wire logic [15:0] FMT_YDAY,
  input wire logic [7:0] FMT_MONTH,
  input wire logic [7:0] FMT_MDAY,
  input wire logic [7:0] FMT_WDAY,
  input wire logic [7:0] FMT_HOUR,
  input wire logic [7:0] FMT_MIN,
  input wire logic [7:0] FMT_SEC,
  input wire logic [2:0][31:0] POS_SDEV,
  input wire logic [2:0][31:0] VEL_SDEV,
  input wire logic [2:0][31:0] ORI_SDEV,
  input wire logic REQ_VALID,
  input wire logic [7:0] REQ_ID,
  output logic REQ_READY,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [7:0] OUT_DATA,
  output logic OUT_FIRST,
  output logic OUT_LAST,
  output logic [7:0] OUT_ID,
  output logic [6:0] OUT_LEN,
  output logic [15:0] SYS_STATUS,
  output logic [15:0] FILT_STATUS,
  output logic [31:0] TIME_SEC,
  output logic [19:0] TIME_USEC
);
  import nstpb_pkg::*;

  typedef logic [PAYLOAD_MAX-1:0][7:0] nstpb_pl_t;

  typedef struct packed {
    nstpb_st_t st;
    logic [7:0] id;
    logic [6:0] len;
    logic [6:0] idx;
    nstpb_pl_t pl;
    logic [31:0] sec;
    logic [19:0] usec;
    logic [4:0] tick;
    logic ovf;
    logic [15:0] sys;
    logic [15:0] filt;
    logic [7:0] data;
    logic valid;
  } nstpb_state_t;

  nstpb_state_t s_r;
  nstpb_state_t s_nxt;

  // Snapshot of one payload, packed bytes with byte 0 lowest
  function automatic nstpb_pl_t build(input logic [7:0] id,
                                      input logic [15:0] sys,
                                      input logic [15:0] filt,
                                      input logic [31:0] sec,
                                      input logic [19:0] usec);
    nstpb_pl_t p;
    p = '0;
    case (id)
      ID_STATE: begin
        p[OFS_SYS +: 2] = sys; // R15
        p[OFS_FILT +: 2] = filt; // R15
        p[OFS_SEC +: 4] = sec; // R15
        p[OFS_USEC +: 4] = {12'h000, usec}; // R15
        p[OFS_STATE_SD +: 12] = POS_SDEV; // R15
      end
      ID_UNIX: begin
        p[0 +: 4] = sec; // R9
        p[4 +: 4] = {12'h000, usec}; // R9
      end
      ID_FMT: begin
        p[0 +: 4] = {12'h000, usec}; // R10
        p[OFS_FMT_YEAR +: 2] = FMT_YEAR; // R10
        p[OFS_FMT_YDAY +: 2] = FMT_YDAY; // R10
        p[OFS_FMT_MON] = FMT_MONTH; // R10
        p[OFS_FMT_MDAY] = FMT_MDAY; // R10
        p[OFS_FMT_WDAY] = FMT_WDAY; // R10
        p[OFS_FMT_HOUR] = FMT_HOUR; // R10
        p[OFS_FMT_MIN] = FMT_MIN; // R10
        p[OFS_FMT_SEC] = FMT_SEC; // R10
      end
      ID_STATUS: begin
        p[OFS_SYS +: 2] = sys; // R11 R16
        p[OFS_FILT +: 2] = filt; // R11
      end
      ID_POS_SD: p[0 +: 12] = POS_SDEV; // R12 R16
      ID_VEL_SD: p[0 +: 12] = VEL_SDEV; // R13
      ID_ORI_SD: p[0 +: 12] = ORI_SDEV; // R14
      default: p = '0;
    endcase
    return p;
  endfunction

  always_comb begin
    s_nxt = s_r;
    // Free-running Unix time
    if (s_r.tick == TICK_LAST) begin
      s_nxt.tick = 5'h00;
      if (s_r.usec == USEC_MAX) begin
        s_nxt.usec = 20'h0_0000; // R8
        s_nxt.sec = s_r.sec + 32'h0000_0001; // R7
      end else begin
        s_nxt.usec = s_r.usec + 20'h0_0001;
      end
    end else begin
      s_nxt.tick = s_r.tick + 5'h01;
    end
    if (TIME_SET) begin
      s_nxt.tick = 5'h00;
      s_nxt.sec = TIME_SEC_SET; // R7
      if (TIME_USEC_SET > USEC_MAX) begin
        s_nxt.usec = USEC_MAX; // R8
      end else begin
        s_nxt.usec = TIME_USEC_SET;
      end
    end
    // Overflow flag: a request refused while busy; set beats clear
    if (REQ_VALID && s_r.st != NSTPB_IDLE) begin
      s_nxt.ovf = 1'b1; // R4
    end else if (OVF_CLR) begin
      s_nxt.ovf = 1'b0;
    end
    s_nxt.sys = {s_nxt.ovf, SYS_FLAGS}; // R1 R2 R3 R4
    s_nxt.filt = FILT_FLAGS; // R5 R6 R2
    case (s_r.st)
      NSTPB_IDLE: begin
        if (REQ_VALID && nstpb_len(REQ_ID) != LEN_NONE) begin
          s_nxt.st = NSTPB_SEND;
          s_nxt.id = REQ_ID;
          s_nxt.len = nstpb_len(REQ_ID);
          s_nxt.idx = 7'h00;
          s_nxt.pl = build(REQ_ID, s_r.sys, s_r.filt, s_r.sec, s_r.usec);
          s_nxt.data = s_nxt.pl[0];
          s_nxt.valid = 1'b1;
        end
      end
      NSTPB_SEND: begin
        if (OUT_READY) begin
          if (s_r.idx == s_r.len - 7'h01) begin
            s_nxt.st = NSTPB_IDLE;
            s_nxt.valid = 1'b0;
          end else begin
            s_nxt.idx = s_r.idx + 7'h01;
            s_nxt.data = s_r.pl[s_nxt.idx]; // R16
          end
        end
      end
      default: begin
        s_nxt.st = NSTPB_IDLE;
        s_nxt.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_r <= '0;
      s_r.st <= NSTPB_IDLE;
      s_r.sec <= SEC_RST;
      s_r.usec <= USEC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign REQ_READY = (s_r.st == NSTPB_IDLE);
  assign OUT_VALID = s_r.valid;
  assign OUT_DATA = s_r.data;
  assign OUT_FIRST = s_r.valid && (s_r.idx == 7'h00);
  assign OUT_LAST = s_r.valid && (s_r.idx == s_r.len - 7'h01);
  assign OUT_ID = s_r.id;
  assign OUT_LEN = s_r.len;
  assign SYS_STATUS = s_r.sys;
  assign FILT_STATUS = s_r.filt;
  assign TIME_SEC = s_r.sec;
  assign TIME_USEC = s_r.usec;

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  chk_usec_in_range: assert property (TIME_USEC <= USEC_MAX) // R8
    else $error("microseconds out of range");

  chk_second_rollover: assert property ( // R7
    (s_r.usec == USEC_MAX && s_r.tick == TICK_LAST && !TIME_SET)
    |=> (TIME_USEC == 20'h0_0000) && (TIME_SEC == $past(TIME_SEC) + 1))
    else $error("second rollover wrong");

  chk_ovf_sets: assert property ( // R4
    (REQ_VALID && !REQ_READY) |=> SYS_STATUS[SYS_OVF_BIT])
    else $error("overflow not flagged");

  chk_sys_flags_follow: assert property ( // R1
    ##1 SYS_STATUS[14:0] == $past(SYS_FLAGS))
    else $error("system status bits wrong");

  chk_filt_follow: assert property (##1 FILT_STATUS == $past(FILT_FLAGS)) // R5
    else $error("filter status wrong");

  chk_unix_len: assert property ( // R9
    (OUT_FIRST && OUT_ID == ID_UNIX) |-> OUT_LEN == LEN_UNIX)
    else $error("unix length wrong");

  chk_fmt_len: assert property ( // R10
    (OUT_FIRST && OUT_ID == ID_FMT) |-> OUT_LEN == LEN_FMT)
    else $error("formatted length wrong");

  chk_status_byte0: assert property ( // R11
    (REQ_READY && REQ_VALID && REQ_ID == ID_STATUS)
    |=> OUT_FIRST && OUT_DATA == $past(SYS_STATUS[7:0]))
    else $error("status byte 0 wrong");

  chk_sd_len: assert property ( // R12
    (OUT_FIRST && (OUT_ID == ID_POS_SD || OUT_ID == ID_VEL_SD ||
     OUT_ID == ID_ORI_SD)) |-> OUT_LEN == LEN_SD)
    else $error("deviation length wrong");

  chk_hold_stall: assert property (
    (OUT_VALID && !OUT_READY) |=> OUT_VALID && $stable(OUT_DATA))
    else $error("byte changed under stall");

  chk_ovf_sticky: assert property ( // R4
    (SYS_STATUS[SYS_OVF_BIT] && !OVF_CLR) |=> SYS_STATUS[SYS_OVF_BIT])
    else $error("overflow bit dropped");

  chk_ovf_clears: assert property ( // R4
    (OVF_CLR && !(REQ_VALID && !REQ_READY)) |=> !SYS_STATUS[SYS_OVF_BIT])
    else $error("overflow bit not cleared");

  chk_tick_range: assert property (s_r.tick <= TICK_LAST) // R8
    else $error("tick counter out of range");

  chk_usec_hold: assert property ( // R8
    (!TIME_SET && s_r.tick != TICK_LAST) |=> $stable(TIME_USEC))
    else $error("microseconds moved off tick");

  chk_time_load: assert property ( // R7
    TIME_SET |=> TIME_SEC == $past(TIME_SEC_SET))
    else $error("seconds not loaded");

  chk_unknown_id: assert property (
    (REQ_READY && REQ_VALID && nstpb_len(REQ_ID) == LEN_NONE)
    |=> REQ_READY && !OUT_VALID)
    else $error("unknown packet started");

  chk_take_header: assert property ( // R9
    (REQ_READY && REQ_VALID && nstpb_len(REQ_ID) != LEN_NONE)
    |=> OUT_VALID && OUT_FIRST && OUT_ID == $past(REQ_ID))
    else $error("packet not started");

  chk_unix_byte0: assert property ( // R9
    (REQ_READY && REQ_VALID && REQ_ID == ID_UNIX)
    |=> OUT_DATA == $past(TIME_SEC[7:0]))
    else $error("unix byte 0 wrong");

  chk_fmt_byte0: assert property ( // R10
    (REQ_READY && REQ_VALID && REQ_ID == ID_FMT)
    |=> OUT_DATA == $past(TIME_USEC[7:0]))
    else $error("formatted byte 0 wrong");

  chk_state_byte0: assert property ( // R15
    (REQ_READY && REQ_VALID && REQ_ID == ID_STATE)
    |=> OUT_DATA == $past(SYS_STATUS[7:0]))
    else $error("state byte 0 wrong");

  chk_pos_byte0: assert property ( // R12
    (REQ_READY && REQ_VALID && REQ_ID == ID_POS_SD)
    |=> OUT_DATA == $past(POS_SDEV[0][7:0]))
    else $error("position byte 0 wrong");

  chk_vel_byte0: assert property ( // R13
    (REQ_READY && REQ_VALID && REQ_ID == ID_VEL_SD)
    |=> OUT_DATA == $past(VEL_SDEV[0][7:0]))
    else $error("velocity byte 0 wrong");

  chk_ori_byte0: assert property ( // R14
    (REQ_READY && REQ_VALID && REQ_ID == ID_ORI_SD)
    |=> OUT_DATA == $past(ORI_SDEV[0][7:0]))
    else $error("orientation byte 0 wrong");

  chk_last_release: assert property (
    (OUT_LAST && OUT_READY) |=> !OUT_VALID && REQ_READY)
    else $error("packet did not end");

  chk_idx_in_len: assert property (OUT_VALID |-> s_r.idx < s_r.len)
    else $error("byte index past length");

  cov_unix_pkt: cover property (OUT_LAST && OUT_READY && OUT_ID == ID_UNIX);
  cov_state_pkt: cover property (OUT_LAST && OUT_READY && OUT_ID == ID_STATE);
  cov_overflow: cover property (REQ_VALID && !REQ_READY);
  cov_rollover: cover property (s_r.usec == USEC_MAX && s_r.tick == TICK_LAST);
  cov_set_wins: cover property (REQ_VALID && !REQ_READY && OVF_CLR);

endmodule

`default_nettype wire

//--- testbench/nstpb_host_model.sv
// Host sink model: accepts builder bytes and keeps the latest packet.
// Assumes the builder byte handshake runs on the same system clock.
`timescale 1ns/1ps
`default_nettype none
module nstpb_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic valid,
  input wire logic first,
  input wire logic last,
  input wire logic [7:0] data,
  input wire logic [7:0] id,
  input wire logic [6:0] len,
  output logic ready
);
  logic [7:0] rx_q [100];
  logic [7:0] got_id;
  logic [6:0] got_len;
  int n;
  int pkts;
  // Stalls every other cycle when slow
  always_ff @(posedge clk) begin
    ready <= rst | ~slow | ~ready;
  end
  // Bytes kept in arrival order, lowest byte of a field first
  always_ff @(posedge clk) begin
    if (rst) begin
      n <= 0;
      pkts <= 0;
    end else if (valid && ready) begin
      rx_q[first ? 0 : n] <= data;
      n <= first ? 1 : n + 1;
      if (first) begin
        got_id <= id;
        got_len <= len;
      end
      if (last) begin
        pkts <= pkts + 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/nstpb_builder_tb.sv
// Self-checking bench for the packet builder.
// Assumes the builder, its package and the host sink model.
`timescale 1ns/1ps
`default_nettype none
module nstpb_builder_tb;
  import nstpb_pkg::*;
  logic clk = 0, reset = 1, ovf_clr = 0, time_set = 0, req_valid = 0, slow = 0;
  logic [14:0] sys_flags = 0;
  logic [15:0] filt_flags = 0, year = 0, yday = 0;
  logic [31:0] sec_set = 0, t_sec;
  logic [19:0] usec_set = 0, t_usec;
  logic [7:0] mon = 0, mday = 0, wday = 0, hour = 0, min_v = 0, sec_v = 0;
  logic [7:0] req_id = 0, out_data, out_id;
  logic [2:0][31:0] pos = 0, vel = 0, ori = 0;
  logic req_ready, out_valid, out_ready, out_first, out_last;
  logic [6:0] out_len;
  logic [15:0] sys_st, filt_st;
  logic [7:0] exp_b [100];
  int mismatches = 0, check_count = 0, cyc = 0;

  nstpb_builder u_nstpb_builder (.CLK_SYS(clk), .RESET(reset),
    .SYS_FLAGS(sys_flags), .FILT_FLAGS(filt_flags), .OVF_CLR(ovf_clr),
    .TIME_SET(time_set), .TIME_SEC_SET(sec_set), .TIME_USEC_SET(usec_set),
    .FMT_YEAR(year), .FMT_YDAY(yday), .FMT_MONTH(mon), .FMT_MDAY(mday),
    .FMT_WDAY(wday), .FMT_HOUR(hour), .FMT_MIN(min_v), .FMT_SEC(sec_v),
    .POS_SDEV(pos), .VEL_SDEV(vel), .ORI_SDEV(ori), .REQ_VALID(req_valid),
    .REQ_ID(req_id), .REQ_READY(req_ready), .OUT_VALID(out_valid),
    .OUT_READY(out_ready), .OUT_DATA(out_data), .OUT_FIRST(out_first),
    .OUT_LAST(out_last), .OUT_ID(out_id), .OUT_LEN(out_len),
    .SYS_STATUS(sys_st), .FILT_STATUS(filt_st), .TIME_SEC(t_sec),
    .TIME_USEC(t_usec));

  nstpb_host_model u_nstpb_host_model (.clk(clk), .rst(reset), .slow(slow),
    .valid(out_valid), .first(out_first), .last(out_last), .data(out_data),
    .id(out_id), .len(out_len), .ready(out_ready));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Expected field, lowest byte first
  task automatic put(input int ofs, input int nb, input logic [31:0] v);
    for (int i = 0; i < nb; i++) exp_b[ofs + i] = v[8 * i +: 8];
  endtask

  task automatic load_time(input logic [31:0] s, input logic [19:0] u);
    sec_set = s;
    usec_set = u;
    time_set = 1;
    step(1);
    time_set = 0;
    step(1);
  endtask

  task automatic send(input logic [7:0] id, input int n);
    int i, k;
    k = u_nstpb_host_model.pkts;
    req_id = id;
    for (i = 0; i < 50 && req_ready !== 1'b1; i++) step(1);
    req_valid = 1;
    step(1);
    req_valid = 0;
    for (i = 0; i < 400 && u_nstpb_host_model.pkts == k; i++) step(1);
    check(32'(u_nstpb_host_model.got_id), 32'(id));
    check(32'(u_nstpb_host_model.got_len), 32'(n));
    check(32'(u_nstpb_host_model.n), 32'(n));
    for (i = 0; i < n; i++) begin
      check(32'(u_nstpb_host_model.rx_q[i]), 32'(exp_b[i]));
    end
  endtask

  initial begin
    logic [2:0][31:0] v;
    step(8);
    reset = 0;
    for (int j = 0; j < 2; j++) begin
      sys_flags = j ? 15'h25C3 : 15'h5A3C;
      filt_flags = j ? 16'h3C5A : 16'hC3A5;
      step(2);
      check(32'(sys_st), 32'(sys_flags));
      check(32'(filt_st), 32'(filt_flags));
      put(0, 2, 32'(sys_flags));
      put(2, 2, 32'(filt_flags));
      send(8'h17, 4);
    end
    $display("test status done");
    load_time(32'h5E0B_E100, 20'hFFFFF);
    check(32'(t_usec), 32'd999999);
    put(0, 4, 32'h5E0B_E100);
    put(4, 4, 32'd999999);
    send(8'h15, 8);
    step(15);
    check(t_sec, 32'h5E0B_E101);
    check(32'(t_usec), 32'h0);
    $display("test unix time done");
    year = 16'h07E8;
    yday = 16'h016D;
    mon = 8'h0B;
    mday = 8'h1F;
    wday = 8'h06;
    hour = 8'h17;
    min_v = 8'h3B;
    sec_v = 8'h3B;
    load_time(32'h0, 20'h00010);
    put(0, 4, 32'h10);
    put(4, 2, 32'h07E8);
    put(6, 2, 32'h016D);
    put(8, 4, 32'h1F0B_0617);
    exp_b[8] = 8'h0B;
    exp_b[9] = 8'h1F;
    exp_b[10] = 8'h06;
    exp_b[11] = 8'h17;
    put(12, 2, 32'h3B3B);
    send(8'h16, 14);
    $display("test formatted time done");
    pos = {32'h4040_0000, 32'h4000_0000, 32'h3F80_0000};
    vel = {32'h3DCC_CCCD, 32'h3E4C_CCCD, 32'h3E99_999A};
    ori = {32'h3A83_126F, 32'h3B03_126F, 32'h3C23_D70A};
    slow = 1;
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? pos : (k == 1) ? vel : ori;
      for (int e = 0; e < 3; e++) put(4 * e, 4, v[e]);
      send(8'h18 + 8'(k), 12);
    end
    slow = 0;
    $display("test deviations done");
    for (int i = 0; i < 100; i++) exp_b[i] = 8'h00;
    load_time(32'h0000_1234, 20'h00005);
    put(0, 2, 32'(sys_flags));
    put(2, 2, 32'(filt_flags));
    put(4, 4, 32'h1234);
    put(8, 4, 32'h5);
    for (int e = 0; e < 3; e++) put(88 + 4 * e, 4, pos[e]);
    send(8'h14, 100);
    $display("test system state done");
    req_id = 8'h17;
    req_valid = 1;
    step(1);
    ovf_clr = 1;
    step(1);
    req_valid = 0;
    ovf_clr = 0;
    check(32'(sys_st[15]), 32'h1);
    step(1);
    check(32'(sys_st[15]), 32'h1);
    step(12);
    ovf_clr = 1;
    step(1);
    ovf_clr = 0;
    step(2);
    check(32'(sys_st[15]), 32'h0);
    $display("test overflow done");
    req_id = 8'h1B;
    req_valid = 1;
    step(1);
    req_valid = 0;
    check(32'(req_ready), 32'h1);
    check(32'(out_valid), 32'h0);
    check(32'(sys_st[15]), 32'h0);
    $display("test unknown id done");
    conclude();
  end
endmodule
`default_nettype wire
